/* inc/usart_slice_pkg.sv */
package usart_slice_pkg;
  // register byte offsets
  localparam logic [7:0] core_control_off       = 8'h00;
  localparam logic [7:0] line_control_two_off   = 8'h04;
  localparam logic [7:0] line_control_three_off = 8'h08;
  localparam logic [7:0] slice_status_off       = 8'h1c;

  // core_control fields
  localparam int unit_enable_bit = 0;
  localparam int rx_enable_bit   = 2;
  localparam int tx_enable_bit   = 3;

  // line_control_two fields
  localparam int node_address_low_lsb  = 24;
  localparam int node_address_high_lsb = 28;
  localparam int node_address_w        = 4;

  // line_control_three fields
  localparam int error_irq_enable_bit        = 0;
  localparam int half_duplex_enable_bit      = 3;
  localparam int dma_receive_enable_bit      = 6;
  localparam int dma_transmit_enable_bit     = 7;
  localparam int request_to_send_enable_bit  = 8;
  localparam int clear_to_send_enable_bit    = 9;

  // slice_status fields
  localparam int char_match_flag_bit    = 0;
  localparam int framing_error_flag_bit = 1;
  localparam int overrun_error_flag_bit = 2;
  localparam int noise_error_flag_bit   = 3;
  localparam int wake_seen_bit          = 4;
  localparam int rts_level_bit          = 8;
  localparam int cts_level_bit          = 9;
  localparam int fifo_full_bit          = 10;
  localparam int fifo_empty_bit         = 11;

  // writable masks, reserved bits read as zero
  localparam logic [31:0] core_control_mask       = 32'h0000_000d;
  localparam logic [31:0] line_control_two_mask   = 32'hff00_0000;
  localparam logic [31:0] line_control_three_mask = 32'h0000_03c9;
  localparam logic [31:0] sticky_flag_mask        = 32'h0000_001f;

  // reset values
  localparam logic [31:0] core_control_rst       = 32'h0000_0000;
  localparam logic [31:0] line_control_two_rst   = 32'h0000_0000;
  localparam logic [31:0] line_control_three_rst = 32'h0000_0000;

  // receive buffer shape
  localparam int rx_fifo_depth = 32;
  localparam int char_width    = 8;
endpackage

/* rtl/node_address_match.sv */
`timescale 1ns/1ps
module node_address_match
  import usart_slice_pkg::*;
(
  // received character
  input  wire logic [char_width-1:0]     char_i,
  input  wire logic                      char_valid_i,
  input  wire logic                      mute_i,
  // node address fields
  input  wire logic [node_address_w-1:0] node_address_low_i,
  input  wire logic [node_address_w-1:0] node_address_high_i,
  // results
  output logic                           char_match_o,
  output logic                           wake_o
);
  logic [char_width-1:0] node_byte;

  assign node_byte = {node_address_high_i, node_address_low_i};

  // character detection in normal reception, mute off
  assign char_match_o = char_valid_i & ~mute_i & (char_i == node_byte);

  // 7-bit address mark: top bit set, lower seven against node address
  assign wake_o = char_valid_i & mute_i & char_i[char_width-1] &
                  (char_i[char_width-2:0] == node_byte[char_width-2:0]);
endmodule

/* rtl/rx_char_fifo.sv */
`timescale 1ns/1ps
module rx_char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  // fill state
  output logic                  full_o,
  output logic                  empty_o
);
  localparam int AW = $clog2(DEPTH);

  // refuse shapes the pointer logic cannot serve
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_shape
    $error("rx_char_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign full_o      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty_o     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_o  = ~full_o;
  assign out_valid_o = ~empty_o;
  assign push        = ce_i & in_valid_i & ~full_o;
  assign pop         = ce_i & out_ready_i & ~empty_o;
  assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

  // storage
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

/* rtl/usart_addr_match_flow_ctrl.sv */
// Summary of operation
// - normal reception: character equal address sets match
// - node address fields give 7-bit wake address
// - address fields writable only receiver or unit off
// - error enable gates framing/overrun/noise interrupt
// - half-duplex bit, writable only unit disabled
// - dma requests gated by their enable bits
// - rts low only while buffer has room
// - start character only while cts low
// - cts high: finish character, hold; bit locked
`timescale 1ns/1ps
module usart_addr_match_flow_ctrl
  import usart_slice_pkg::*;
#(
  parameter int FIFO_DEPTH = rx_fifo_depth
) (
  // clock, reset, enable
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // receiver side of the unit
  input  wire logic                  rx_valid_i,
  output logic                       rx_ready_o,
  input  wire logic [char_width-1:0] rx_data_i,
  input  wire logic                  mute_i,
  input  wire logic                  framing_error_i,
  input  wire logic                  overrun_error_i,
  input  wire logic                  noise_error_i,
  // receive buffer drain
  output logic                       rxb_valid_o,
  input  wire logic                  rxb_ready_i,
  output logic      [char_width-1:0] rxb_data_o,
  // transmitter side of the unit
  input  wire logic                  tx_pending_i,
  input  wire logic                  tx_busy_i,
  input  wire logic                  tx_empty_i,
  output logic                       tx_start_o,
  // line flow control pins
  input  wire logic                  cts_b_i,
  output logic                       rts_b_o,
  // dma, interrupt, mode and wake
  output logic                       rx_dma_req_o,
  output logic                       tx_dma_req_o,
  output logic                       error_irq_o,
  output logic                       half_duplex_o,
  output logic                       wake_o
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("usart_addr_match_flow_ctrl: FIFO_DEPTH must be at least 2");
  end

  // registers
  logic [31:0] core_control_reg;
  logic [31:0] line_control_two_reg;
  logic [31:0] line_control_three_reg;
  logic [31:0] flags_reg;
  logic [31:0] flags_next;
  logic [31:0] rd_data_next;
  logic [31:0] wb_dat_reg;
  logic        ack_reg;
  logic        rts_b_reg;

  // bus decode
  logic        bus_req;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [31:0] lane_mask;
  logic        hit_core;
  logic        hit_two;
  logic        hit_three;
  logic        hit_status;

  // derived control
  logic        unit_enable;
  logic        rx_enable;
  logic        tx_enable;
  logic        addr_lock;
  logic        unit_lock;
  logic [31:0] three_mask;
  logic [31:0] two_mask;

  // datapath
  logic        fifo_full;
  logic        fifo_empty;
  logic        fifo_in_ready;
  logic        rx_take;
  logic        match_evt;
  logic        wake_evt;
  logic        cts_ok;

  // one slave access per request, ack drops the cycle after
  assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_strobe = ce_i & bus_req & wb_we_i;
  assign rd_strobe = ce_i & bus_req & ~wb_we_i;

  assign hit_core   = (wb_adr_i == core_control_off);
  assign hit_two    = (wb_adr_i == line_control_two_off);
  assign hit_three  = (wb_adr_i == line_control_three_off);
  assign hit_status = (wb_adr_i == slice_status_off);

  // byte lane enables widened to a bit mask
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
  end

  // enables of the wider unit
  assign unit_enable = core_control_reg[unit_enable_bit];
  assign rx_enable   = core_control_reg[rx_enable_bit];
  assign tx_enable   = core_control_reg[tx_enable_bit];

  // write locks
  assign addr_lock = unit_enable & rx_enable;
  assign unit_lock = unit_enable;

  // address field write mask follows the receiver/unit state
  assign two_mask = addr_lock ? 32'h0000_0000 : line_control_two_mask;

  // locked bits drop out of the mask while the unit runs
  always_comb begin
    three_mask = line_control_three_mask;
    if (unit_lock) begin
      three_mask[half_duplex_enable_bit]     = 1'b0;
      three_mask[clear_to_send_enable_bit]   = 1'b0;
      three_mask[request_to_send_enable_bit] = 1'b0;
    end
  end

  // core control register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      core_control_reg <= core_control_rst;
    end else if (wr_strobe && hit_core) begin
      core_control_reg <= (core_control_reg & ~(lane_mask & core_control_mask)) |
                          (wb_dat_i & lane_mask & core_control_mask);
    end
  end

  // node address register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      line_control_two_reg <= line_control_two_rst;
    end else if (wr_strobe && hit_two) begin
      line_control_two_reg <= (line_control_two_reg & ~(lane_mask & two_mask)) |
                              (wb_dat_i & lane_mask & two_mask);
    end
  end

  // interrupt, mode, dma and flow control enables
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      line_control_three_reg <= line_control_three_rst;
    end else if (wr_strobe && hit_three) begin
      line_control_three_reg <= (line_control_three_reg & ~(lane_mask & three_mask)) |
                                (wb_dat_i & lane_mask & three_mask);
    end
  end

  // receive buffer, back pressure reaches the receiver
  rx_char_fifo #(
    .WIDTH (char_width),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_valid_i  (rx_take),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_data_i),
    .out_valid_o (rxb_valid_o),
    .out_ready_i (rxb_ready_i),
    .out_data_o  (rxb_data_o),
    .full_o      (fifo_full),
    .empty_o     (fifo_empty)
  );

  // only an enabled receiver delivers characters
  assign rx_ready_o = fifo_in_ready & unit_enable & rx_enable;
  assign rx_take    = rx_valid_i & rx_ready_o;

  // address comparison on each accepted character
  node_address_match u_match (
    .char_i              (rx_data_i),
    .char_valid_i        (rx_take),
    .mute_i              (mute_i),
    .node_address_low_i  (line_control_two_reg[node_address_low_lsb +: node_address_w]),
    .node_address_high_i (line_control_two_reg[node_address_high_lsb +: node_address_w]),
    .char_match_o        (match_evt),
    .wake_o              (wake_evt)
  );

  assign wake_o = ce_i & wake_evt;

  // sticky flags: set wins over a write-one clear in the same cycle
  always_comb begin
    flags_next = flags_reg;
    if (wr_strobe && hit_status) begin
      flags_next = flags_next & ~(wb_dat_i & lane_mask & sticky_flag_mask);
    end
    if (match_evt) begin
      flags_next[char_match_flag_bit] = 1'b1;
    end
    if (framing_error_i) begin
      flags_next[framing_error_flag_bit] = 1'b1;
    end
    if (overrun_error_i) begin
      flags_next[overrun_error_flag_bit] = 1'b1;
    end
    if (noise_error_i) begin
      flags_next[noise_error_flag_bit] = 1'b1;
    end
    if (wake_evt) begin
      flags_next[wake_seen_bit] = 1'b1;
    end
  end

  // flag storage
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      flags_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      flags_reg <= flags_next;
    end
  end

  // error interrupt level while any error flag stands
  assign error_irq_o = line_control_three_reg[error_irq_enable_bit] &
                       (flags_reg[framing_error_flag_bit] |
                        flags_reg[overrun_error_flag_bit] |
                        flags_reg[noise_error_flag_bit]);

  assign half_duplex_o = line_control_three_reg[half_duplex_enable_bit];

  // dma requests
  assign rx_dma_req_o = line_control_three_reg[dma_receive_enable_bit] & rxb_valid_o;
  assign tx_dma_req_o = line_control_three_reg[dma_transmit_enable_bit] &
                        unit_enable & tx_enable & tx_empty_i;

  // rts: low while the receive buffer has room and the receiver is enabled, registered pin
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rts_b_reg <= 1'b1;
    end else if (ce_i) begin
      if (line_control_three_reg[request_to_send_enable_bit]) begin
        rts_b_reg <= fifo_full | ~(unit_enable & rx_enable);
      end else begin
        rts_b_reg <= 1'b0;
      end
    end
  end

  assign rts_b_o = rts_b_reg;

  // a new character starts only with cts low; one in flight finishes
  assign cts_ok     = ~line_control_three_reg[clear_to_send_enable_bit] | ~cts_b_i;
  assign tx_start_o = ce_i & unit_enable & tx_enable & tx_pending_i &
                      ~tx_busy_i & cts_ok;

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_data_next = 32'h0000_0000;
    if (hit_core) begin
      rd_data_next = core_control_reg & core_control_mask;
    end else if (hit_two) begin
      rd_data_next = line_control_two_reg & line_control_two_mask;
    end else if (hit_three) begin
      rd_data_next = line_control_three_reg & line_control_three_mask;
    end else if (hit_status) begin
      rd_data_next = flags_reg & sticky_flag_mask;
      rd_data_next[rts_level_bit]  = rts_b_reg;
      rd_data_next[cts_level_bit]  = cts_b_i;
      rd_data_next[fifo_full_bit]  = fifo_full;
      rd_data_next[fifo_empty_bit] = fifo_empty;
    end
  end

  // registered read data
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wb_dat_reg <= 32'h0000_0000;
    end else if (rd_strobe) begin
      wb_dat_reg <= rd_data_next;
    end
  end

  // acknowledge one cycle after the request, every offset answered
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= bus_req;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = wb_dat_reg;
endmodule

/* sim/remote_serial_model.sv */
`timescale 1ns/1ps
// far-side station: offers queued characters, honours our rts, drives cts
module remote_serial_model (
  // clock and flow pins
  input  wire logic       core_clk_i,
  input  wire logic       rts_b_i,
  input  wire logic       block_i,
  // character handshake toward the receiver
  input  wire logic       ready_i,
  output logic            valid_o,
  output logic      [7:0] data_o,
  output logic            cts_b_o
);
  logic [7:0] q[$];
  logic [7:0] last;

  // cts follows the bench's stall request
  assign cts_b_o = block_i;

  initial begin
    valid_o = 1'b0;
    data_o  = 8'h00;
    last    = 8'h00;
  end

  // hold a char until taken, idle line shows the inverse of the last one
  always @(posedge core_clk_i) begin
    if (valid_o && ready_i) begin
      void'(q.pop_front());
      valid_o <= 1'b0;
      data_o  <= ~last;
    end else if (!valid_o && q.size() != 0 && !rts_b_i) begin
      valid_o <= 1'b1;
      data_o  <= q[0];
      last    <= q[0];
    end
  end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import usart_slice_pkg::*;
  logic        core_clk, rst_b, cyc, stb, we, rxb_ready, mute, tx_pending, tx_busy, tx_empty, block;
  logic [7:0]  adr, node, c;
  logic [31:0] wdat, q;
  logic [2:0]  err_v;
  wire logic [31:0] rdat;
  wire logic        rx_valid, rx_ready, ack, rxb_valid, tx_start, cts_b, rts_b;
  wire logic        rx_dma, tx_dma, irq, hd, wake;
  wire logic [7:0]  rx_data, rxb_data;
  logic [7:0]  ref_q[$];
  int          miscompares, checked, cyc_cnt, n, wake_cnt;

  usart_addr_match_flow_ctrl #(.FIFO_DEPTH(rx_fifo_depth)) u_dut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_data_i(rx_data),
    .mute_i(mute), .framing_error_i(err_v[0]), .overrun_error_i(err_v[1]),
    .noise_error_i(err_v[2]), .rxb_valid_o(rxb_valid), .rxb_ready_i(rxb_ready),
    .rxb_data_o(rxb_data), .tx_pending_i(tx_pending), .tx_busy_i(tx_busy),
    .tx_empty_i(tx_empty), .tx_start_o(tx_start), .cts_b_i(cts_b), .rts_b_o(rts_b),
    .rx_dma_req_o(rx_dma), .tx_dma_req_o(tx_dma), .error_irq_o(irq), .half_duplex_o(hd),
    .wake_o(wake));

  remote_serial_model u_far (
    .core_clk_i(core_clk), .rts_b_i(rts_b), .block_i(block), .ready_i(rx_ready),
    .valid_o(rx_valid), .data_o(rx_data), .cts_b_o(cts_b));

  // clock and hang guard
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (wake === 1'b1) wake_cnt++;
    if (cyc_cnt == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin @(posedge core_clk); k++; end while (ack !== 1'b1 && k < 50);
    q = rdat;
    if (k >= 50) miscompares++;
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task automatic send(input logic [7:0] ch);
    int k;
    u_far.q.push_back(ch);
    ref_q.push_back(ch);
    k = 0;
    while (u_far.q.size() != 0 && k < 100) begin @(posedge core_clk); k++; end
    repeat (2) @(posedge core_clk);
  endtask

  // pop every char and compare with the reference queue
  task automatic drain();
    int k;
    k = 0;
    @(posedge core_clk);
    rxb_ready <= 1'b1;
    while (ref_q.size() != 0 && k < 200) begin
      @(posedge core_clk);
      k++;
      if (rxb_valid === 1'b1) chk("rx char", ref_q.pop_front(), rxb_data);
    end
    if (k >= 200) miscompares++;
    rxb_ready <= 1'b0;
  endtask

  initial begin
    core_clk = 0; rst_b = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; rxb_ready = 0;
    mute = 0; tx_pending = 0; tx_busy = 0; tx_empty = 1; block = 1; err_v = 0;
    miscompares = 0; checked = 0; cyc_cnt = 0; wake_cnt = 0;
    void'($urandom(47170));
    node = 8'($urandom);
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values, reserved bits, unmapped place
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", 32'h0, q);
    end
    bus(1'b1, line_control_three_off, 32'hffff_ffff);
    bus(1'b0, line_control_three_off, 32'h0);
    chk("ctrl3 mask", line_control_three_mask, q);
    bus(1'b1, line_control_two_off, 32'hffff_ffff);
    bus(1'b0, line_control_two_off, 32'h0);
    chk("ctrl2 mask", line_control_two_mask, q);
    bus(1'b1, 8'h30, 32'hffff_ffff);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, q);
    // program node, enable, then try the locked fields
    bus(1'b1, line_control_two_off, {node, 24'h0});
    bus(1'b1, core_control_off, 32'h0000_000d);
    bus(1'b1, line_control_two_off, 32'h0);
    bus(1'b0, line_control_two_off, 32'h0);
    chk("node locked", {node, 24'h0}, q);
    bus(1'b1, line_control_three_off, 32'h0);
    bus(1'b0, line_control_three_off, 32'h0);
    chk("ctrl3 locked", 32'h0000_0308, q);
    chk("half duplex", 32'h1, hd);
    chk("tx dma off", 32'h0, tx_dma);
    // character match and wake
    bus(1'b1, slice_status_off, 32'h1f);
    send(node ^ 8'h01);
    bus(1'b0, slice_status_off, 32'h0);
    chk("no match", 32'h0, q & 32'h1f);
    send(node);
    bus(1'b0, slice_status_off, 32'h0);
    chk("match", 32'h1, q & 32'h1f);
    bus(1'b1, slice_status_off, 32'h1f);
    mute <= 1'b1;
    send({1'b1, node[6:0]});
    mute <= 1'b0;
    bus(1'b0, slice_status_off, 32'h0);
    chk("wake seen", 32'h10, q & 32'h10);
    chk("wake pulse", 32'h1, wake_cnt);
    chk("rx dma off", 32'h0, rx_dma);
    bus(1'b1, line_control_three_off, 32'h0000_00c0);
    #1;
    chk("rx dma on", 32'h1, rx_dma);
    chk("tx dma on", 32'h1, tx_dma);
    drain();
    #1;
    chk("rx dma empty", 32'h0, rx_dma);
    // fill until refused, stall, then drain
    for (int i = 0; i < rx_fifo_depth; i++) begin
      c = 8'($urandom);
      u_far.q.push_back(c);
      ref_q.push_back(c);
    end
    n = 0;
    while (rx_ready !== 1'b0 && n < 300) begin @(posedge core_clk); n++; end
    repeat (10) @(posedge core_clk);
    #1;
    chk("ready full", 32'h0, rx_ready);
    chk("rts full", 32'h1, rts_b);
    drain();
    repeat (2) @(posedge core_clk);
    #1;
    chk("rts room", 32'h0, rts_b);
    // clear to send gating
    @(posedge core_clk);
    tx_pending <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("cts blocks", 32'h0, tx_start);
    @(posedge core_clk);
    block <= 1'b0;
    #1;
    chk("cts allows", 32'h1, tx_start);
    @(posedge core_clk);
    tx_busy <= 1'b1;
    #1;
    chk("busy holds", 32'h0, tx_start);
    // error interrupt per source, then masked
    bus(1'b1, line_control_three_off, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      err_v <= 3'(1 << i);
      @(posedge core_clk);
      err_v <= 3'b000;
      @(posedge core_clk);
      #1;
      chk("irq set", 32'h1, irq);
      bus(1'b1, slice_status_off, 32'h1f);
      #1;
      chk("irq clear", 32'h0, irq);
    end
    bus(1'b1, line_control_three_off, 32'h0);
    @(posedge core_clk);
    err_v <= 3'b001;
    @(posedge core_clk);
    err_v <= 3'b000;
    @(posedge core_clk);
    #1;
    chk("irq masked", 32'h0, irq);
    end_sim();
  end
endmodule

/* sim/usart_slice_monitor.sv */
`timescale 1ns/1ps
module usart_slice_monitor
  import usart_slice_pkg::*;
(
  // clock, reset, bus
  input wire logic                  core_clk_i,
  input wire logic                  rst_b_i,
  input wire logic                  ce_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic                  wb_ack_o,
  // receive path
  input wire logic                  rx_valid_i,
  input wire logic                  rx_ready_o,
  input wire logic [char_width-1:0] rx_data_i,
  input wire logic                  mute_i,
  input wire logic                  framing_error_i,
  input wire logic                  overrun_error_i,
  input wire logic                  noise_error_i,
  input wire logic                  rxb_valid_o,
  // transmit, flow and events
  input wire logic                  tx_pending_i,
  input wire logic                  tx_busy_i,
  input wire logic                  tx_start_o,
  input wire logic                  rts_b_o,
  input wire logic                  rx_dma_req_o,
  input wire logic                  error_irq_o,
  input wire logic                  wake_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_RTS_EMPTY: assert property ($past(rst_b_i) && $past(ce_i) && $past(rx_ready_o) |-> !rts_b_o)
    else $error("rts high while buffer had room");
  AST_RTS_FULL: assert property ($rose(rts_b_o) |-> !$past(rx_ready_o))
    else $error("rts rose while buffer had room");
  AST_TX_START: assert property (tx_start_o |-> tx_pending_i && !tx_busy_i)
    else $error("start while shifter busy or nothing pending");
  AST_RX_DMA: assert property (rx_dma_req_o |-> rxb_valid_o)
    else $error("receive dma request with empty buffer");
  AST_WAKE: assert property (wake_o |-> mute_i && rx_valid_i && rx_ready_o && rx_data_i[7])
    else $error("wake pulse without address mark in mute");
  AST_PUSH: assert property (ce_i && rx_valid_i && rx_ready_o |=> rxb_valid_o)
    else $error("accepted char not in buffer");
  AST_IRQ_CAUSE: assert property ($rose(error_irq_o) |->
      $past(framing_error_i) || $past(overrun_error_i) || $past(noise_error_i) ||
      ($past(wb_cyc_i) && $past(wb_we_i)))
    else $error("error interrupt without error event");
endmodule

bind usart_addr_match_flow_ctrl usart_slice_monitor u_mon (
  .core_clk_i, .rst_b_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .rx_valid_i, .rx_ready_o, .rx_data_i, .mute_i, .framing_error_i, .overrun_error_i,
  .noise_error_i, .rxb_valid_o, .tx_pending_i, .tx_busy_i, .tx_start_o, .rts_b_o,
  .rx_dma_req_o, .error_irq_o, .wake_o
);
